// ==== core/sss_cmd_core.sv ====
// Sensor-side bus engine, command interpreter and status word.
// Assumes the host is the only bus controller and the pins are open drain.
`timescale 1ns/1ps
`default_nettype none
module sss_cmd_core (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Bus pins; the data line is open drain and driven low when the enable is low.
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_o,
	output logic             o_sda_oe_n,
	// Events from the rest of the sensor, one-cycle pulses on i_clk.
	input  wire logic        i_soft_rst_evt,
	input  wire logic        i_supply_fail_evt,
	input  wire logic        i_rh_alert_evt,
	input  wire logic        i_t_alert_evt,
	// State shown to the rest of the sensor.
	output logic             o_heater_on,
	output sss_pkg::sss_status_s o_status
);
	import sss_pkg::*;

	// Synchronised pins and their previous samples.
	logic [1:0]  pins_s;     // Synchronised clock and data lines.
	logic        scl_s;      // Synchronised clock line.
	logic        sda_s;      // Synchronised data line.
	logic        scl_p_q;    // Clock line one cycle earlier.
	logic        sda_p_q;    // Data line one cycle earlier.

	// Bus engine state.
	sss_mode_e   mode_q;     // Current transfer mode.
	logic [3:0]  bit_cnt_q;  // Data bits seen in the current byte.
	logic        in_ack_q;   // High during the acknowledge slot.
	logic [7:0]  shift_q;    // Received bits.
	logic [7:0]  tx_q;       // Byte being sent, top bit on the line.
	logic        oe_n_q;     // Data line enable, low pulls the line low.
	logic [2:0]  wr_idx_q;   // Position of the next written byte.
	logic [1:0]  rd_idx_q;   // Position of the next read byte.
	logic [7:0]  cmd_msb_q;  // First command byte.
	logic [15:0] rd_word_q;  // Status snapshot for a read.
	logic        rd_sel_q;   // Last command asked for the status word.

	// Status flags.
	logic        heater_q;      // Heater switched on.
	logic        alert_pend_q;  // At least one alert pending.
	logic        rh_alert_q;    // Humidity tracking alert.
	logic        t_alert_q;     // Temperature tracking alert.
	logic        sys_rst_q;     // A reset was seen since the last clear.
	logic        cmd_err_q;     // Last command not processed.
	logic        wcrc_err_q;    // Last write checksum failed.

	// Decoded bus events.
	logic        scl_rise;      // Clock line went high.
	logic        scl_fall;      // Clock line went low.
	logic        start_det;     // Data fell while the clock was high.
	logic        stop_det;      // Data rose while the clock was high.
	logic        bit_take;      // Sample a data bit.
	logic        ack_enter;     // Clock fell after the eighth bit.
	logic        ack_end;       // Clock fell at the end of the acknowledge slot.
	logic        ack_rise;      // Clock rose inside the acknowledge slot.
	logic        tx_shift;      // Move to the next bit being sent.
	logic        addr_hit;      // Address byte names this sensor.
	logic        rd_ok;         // A read header that we can answer.

	// Decoded command and data events.
	logic        wr_byte;       // A written byte is complete.
	logic [15:0] cmd_word;      // Command just received.
	logic        cmd_exec;      // A command word is complete.
	logic        cmd_heat_on;   // Heater on command.
	logic        cmd_heat_off;  // Heater off command.
	logic        cmd_clear;     // Clear status command.
	logic        cmd_rd_stat;   // Status read command.
	logic        cmd_ok;        // A command that this block carries out.
	logic        crc_chk;       // A written checksum byte is complete.
	logic        crc_bad;       // The written checksum did not match.
	logic        any_reset;     // Soft reset from the rest of the sensor.
	logic [2:0]  wr_idx_d;      // Position after the current written byte.

	// Checksum engine hookup.
	logic        crc_start;     // First byte of a word.
	logic        crc_next;      // Second byte of a word.
	logic [7:0]  crc_byte;      // Byte fed to the checksum.
	logic [7:0]  crc_val;       // Checksum of the current word.
	logic [7:0]  rd_byte;       // Byte chosen for the next read slot.

	// Both pins cross from the outside world before any decoding.
	sss_sync2 u_sync (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_pins ({i_scl, i_sda}),
		.o_pins (pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// Keep one earlier sample of each line for edge detection.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Line edges and bus conditions.
	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign bit_take  = scl_rise & ~in_ack_q & (bit_cnt_q != BITS_PER_BYTE);
	assign ack_enter = scl_fall & ~in_ack_q & (bit_cnt_q == BITS_PER_BYTE);
	assign ack_end   = scl_fall & in_ack_q;
	assign ack_rise  = scl_rise & in_ack_q;
	assign tx_shift  = scl_fall & ~in_ack_q & (bit_cnt_q != BITS_PER_BYTE) & (mode_q == MD_READ);
	assign addr_hit  = (shift_q[7:1] == BUS_ADDR);
	// Only the status word can be read here; other read headers are not answered.
	assign rd_ok     = shift_q[0] & rd_sel_q;

	// Command decode happens on the acknowledge of the second command byte.
	assign wr_byte      = ack_enter & (mode_q == MD_WRITE);
	assign cmd_word     = {cmd_msb_q, shift_q};
	assign cmd_exec     = wr_byte & (wr_idx_q == WR_CMD_LSB);
	assign cmd_heat_on  = cmd_exec & (cmd_word == CMD_HEATER_ON);
	assign cmd_heat_off = cmd_exec & (cmd_word == CMD_HEATER_OFF);
	assign cmd_clear    = cmd_exec & (cmd_word == CMD_CLEAR_STAT);
	assign cmd_rd_stat  = cmd_exec & (cmd_word == CMD_READ_STAT);
	assign cmd_ok       = cmd_heat_on | cmd_heat_off | cmd_clear | cmd_rd_stat;
	assign crc_chk      = wr_byte & (wr_idx_q == WR_DATA_CRC);
	assign crc_bad      = (shift_q != crc_val);
	assign any_reset    = i_soft_rst_evt;
	// Data words repeat as triplets of two bytes and their checksum.
	assign wr_idx_d     = (wr_idx_q == WR_DATA_CRC) ? WR_DATA_MSB : wr_idx_q + 3'h1;

	// The checksum restarts on each word's first byte in either direction.
	assign crc_start = (wr_byte & (wr_idx_q == WR_DATA_MSB))
		| (ack_end & (mode_q == MD_READ) & (rd_idx_q == RD_MSB));
	assign crc_next  = (wr_byte & (wr_idx_q == WR_DATA_LSB))
		| (ack_end & (mode_q == MD_READ) & (rd_idx_q == RD_LSB));
	assign crc_byte  = (mode_q == MD_READ) ? rd_byte : shift_q;
	assign rd_byte   = (rd_idx_q == RD_MSB) ? rd_word_q[15:8]
		: (rd_idx_q == RD_LSB) ? rd_word_q[7:0] : crc_val;

	sss_crc8 u_crc (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_start (crc_start),
		.i_next  (crc_next),
		.i_byte  (crc_byte),
		.o_crc   (crc_val)
	);

	// Mode sequencing; a start always wins, and a stop always returns to idle.
	always_ff @(posedge i_clk) begin
		if (i_rst || stop_det) begin
			mode_q <= MD_IDLE;
		end else if (start_det) begin
			mode_q <= MD_ADDR;
		end else if (ack_enter && mode_q == MD_ADDR) begin
			// Unknown address or unanswerable read: stay silent until the next start or stop.
			mode_q <= !addr_hit ? MD_HOLD : shift_q[0] ? (rd_ok ? MD_READ : MD_HOLD) : MD_WRITE;
		end else if (ack_rise && mode_q == MD_READ && sda_s) begin
			// The host did not acknowledge, so the read is over.
			mode_q <= MD_HOLD;
		end
	end

	// Bit and slot counting.
	always_ff @(posedge i_clk) begin
		if (i_rst || start_det || stop_det) begin
			bit_cnt_q <= 4'h0;
			in_ack_q  <= 1'b0;
		end else if (bit_take) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end else if (ack_enter) begin
			in_ack_q  <= 1'b1;
		end else if (ack_end) begin
			bit_cnt_q <= 4'h0;
			in_ack_q  <= 1'b0;
		end
	end

	// Receive shifter, most significant bit first.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			shift_q <= 8'h00;
		end else if (bit_take) begin
			shift_q <= {shift_q[6:0], sda_s};
		end
	end

	// Drive the data line: acknowledges low, read bytes bit by bit, else released.
	always_ff @(posedge i_clk) begin
		if (i_rst || start_det || stop_det) begin
			oe_n_q <= 1'b1;
			tx_q   <= 8'h00;
		end else if (ack_enter) begin
			// Pull low for a matched write or answerable read header, or a written byte, release during read acks.
			oe_n_q <= ~(((mode_q == MD_ADDR) & addr_hit & (~shift_q[0] | rd_ok)) | (mode_q == MD_WRITE));
		end else if (ack_end) begin
			// A new read byte goes out on the fall that ends the slot.
			tx_q   <= rd_byte;
			oe_n_q <= (mode_q == MD_READ) ? rd_byte[7] : 1'b1;
		end else if (tx_shift) begin
			tx_q   <= {tx_q[6:0], 1'b0};
			oe_n_q <= tx_q[6];
		end
	end

	// Byte positions of a write and of a read.
	always_ff @(posedge i_clk) begin
		if (i_rst || start_det) begin
			wr_idx_q <= WR_CMD_MSB;
			rd_idx_q <= RD_MSB;
		end else begin
			if (wr_byte) begin
				wr_idx_q <= wr_idx_d;
			end
			if (ack_end && mode_q == MD_READ) begin
				rd_idx_q <= (rd_idx_q == RD_CRC) ? RD_MSB : rd_idx_q + 2'h1;
			end
		end
	end

	// Command byte holder, read selector and status snapshot.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cmd_msb_q <= 8'h00;
			rd_sel_q  <= 1'b0;
			rd_word_q <= 16'h0000;
		end else begin
			if (wr_byte && wr_idx_q == WR_CMD_MSB) begin
				cmd_msb_q <= shift_q;
			end
			if (cmd_exec) begin
				rd_sel_q <= cmd_rd_stat;
			end
			// Snapshot once, so a flag changing mid-read cannot break the checksum.
			if (ack_enter && mode_q == MD_ADDR) begin
				rd_word_q <= o_status;
			end
		end
	end

	// Heater control; a hard or soft reset turns it off, a supply fail does not.
	always_ff @(posedge i_clk) begin
		if (i_rst || any_reset) begin
			heater_q <= 1'b0;
		end else if (cmd_heat_on) begin
			heater_q <= 1'b1;
		end else if (cmd_heat_off) begin
			heater_q <= 1'b0;
		end
	end

	// Sticky flags: a setting event in the same cycle as a clear is kept.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			alert_pend_q <= RST_ALERT_PEND;
			sys_rst_q    <= RST_SYS_RESET;
			rh_alert_q   <= 1'b0;
			t_alert_q    <= 1'b0;
		end else begin
			alert_pend_q <= (i_rh_alert_evt | i_t_alert_evt) | (alert_pend_q & ~cmd_clear);
			rh_alert_q   <= i_rh_alert_evt | (rh_alert_q & ~cmd_clear);
			t_alert_q    <= i_t_alert_evt | (t_alert_q & ~cmd_clear);
			sys_rst_q    <= any_reset | i_supply_fail_evt | (sys_rst_q & ~cmd_clear);
		end
	end

	// Command and write checksum outcome flags.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cmd_err_q  <= 1'b0;
			wcrc_err_q <= 1'b0;
		end else if (cmd_exec) begin
			cmd_err_q  <= ~cmd_ok;
		end else if (crc_chk) begin
			// A bad data checksum also sets the command error flag, though the command already took effect.
			cmd_err_q  <= crc_bad;
			wcrc_err_q <= crc_bad;
		end
	end

	// Outputs come straight from the flags; reserved bits are held at zero.
	assign o_sda_o     = 1'b0;
	assign o_sda_oe_n  = oe_n_q;
	assign o_heater_on = heater_q;
	assign o_status    = '{
		alert_pend : alert_pend_q,
		rsv14      : 1'b0,
		heater     : heater_q,
		rsv12      : 1'b0,
		rh_alert   : rh_alert_q,
		t_alert    : t_alert_q,
		rsv9_5     : 5'h00,
		sys_reset  : sys_rst_q,
		rsv3_2     : 2'h0,
		cmd_err    : cmd_err_q,
		wcrc_err   : wcrc_err_q
	};

endmodule
`default_nettype wire

// ==== common/sss_pkg.sv ====
// Shared constants, types and the checksum step for the sensor command block.
// Assumes a single 100 MHz clock domain and a host that drives the two-wire bus.
package sss_pkg;

	// Bus address of the sensor; the value is arbitrary.
	localparam logic [6:0]  BUS_ADDR        = 7'h45;

	// Command words, most significant byte first on the bus.
	localparam logic [15:0] CMD_HEATER_ON   = 16'h306D;
	localparam logic [15:0] CMD_HEATER_OFF  = 16'h3066;
	localparam logic [15:0] CMD_CLEAR_STAT  = 16'h3041;
	// Status read command; the value is arbitrary.
	localparam logic [15:0] CMD_READ_STAT   = 16'h30A5;

	// Checksum generator properties.
	localparam logic [7:0]  CRC_POLY        = 8'h31;
	localparam logic [7:0]  CRC_INIT        = 8'hFF;
	localparam logic [7:0]  CRC_FINAL_XOR   = 8'h00;

	// Bit counting on the bus: eight data bits, then one acknowledge slot.
	localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

	// Write byte positions: two command bytes, then data words with a checksum each.
	localparam logic [2:0]  WR_CMD_MSB      = 3'h0;
	localparam logic [2:0]  WR_CMD_LSB      = 3'h1;
	localparam logic [2:0]  WR_DATA_MSB     = 3'h2;
	localparam logic [2:0]  WR_DATA_LSB     = 3'h3;
	localparam logic [2:0]  WR_DATA_CRC     = 3'h4;

	// Read byte positions within one word.
	localparam logic [1:0]  RD_MSB          = 2'h0;
	localparam logic [1:0]  RD_LSB          = 2'h1;
	localparam logic [1:0]  RD_CRC          = 2'h2;

	// Reset values of the status flags.
	localparam logic        RST_ALERT_PEND  = 1'b1;
	localparam logic        RST_SYS_RESET   = 1'b1;

	// Bus engine modes.
	typedef enum logic [2:0] {
		MD_IDLE  = 3'b000,
		MD_ADDR  = 3'b001,
		MD_WRITE = 3'b010,
		MD_READ  = 3'b011,
		MD_HOLD  = 3'b100
	} sss_mode_e;

	// The sixteen-bit status word as seen by the host.
	typedef struct packed {
		logic       alert_pend;
		logic       rsv14;
		logic       heater;
		logic       rsv12;
		logic       rh_alert;
		logic       t_alert;
		logic [4:0] rsv9_5;
		logic       sys_reset;
		logic [1:0] rsv3_2;
		logic       cmd_err;
		logic       wcrc_err;
	} sss_status_s;

	// One byte through the checksum, most significant bit first, no reflection.
	function automatic logic [7:0] sss_crc8_step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

endpackage

// ==== core/sss_sync2.sv ====
// Two-flop synchroniser for the clock and data pins of the bus.
// Assumes the pins change freely against i_clk; only the second stage is read.
`timescale 1ns/1ps
`default_nettype none
module sss_sync2 (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Raw pins, bit 1 is the clock line and bit 0 the data line.
	input  wire logic [1:0] i_pins,
	// Synchronised pins.
	output logic      [1:0] o_pins
);

	logic [1:0] meta_q;  // First stage, read only by the second stage.
	logic [1:0] sync_q;  // Second stage, safe for logic.

	// Both lines idle high, so reset parks the stages at one to avoid a false start.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= 2'h3;
			sync_q <= 2'h3;
		end else begin
			meta_q <= i_pins;
			sync_q <= meta_q;
		end
	end

	assign o_pins = sync_q;

endmodule
`default_nettype wire

// ==== core/sss_crc8.sv ====
// Running checksum over the bytes of one word, used for both directions.
// Assumes bytes arrive at most one per clock and that the owner starts each word.
`timescale 1ns/1ps
`default_nettype none
module sss_crc8 (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Byte strobes: start restarts from the initial value, next continues.
	input  wire logic       i_start,
	input  wire logic       i_next,
	input  wire logic [7:0] i_byte,
	// Checksum of the bytes since the last start.
	output logic      [7:0] o_crc
);
	import sss_pkg::*;

	logic [7:0] crc_q;  // Running remainder.
	logic [7:0] seed;   // Remainder that the new byte is folded into.
	logic [7:0] crc_d;  // Remainder after the new byte.

	// A start ignores any earlier word, so only the two latest bytes count.
	assign seed  = i_start ? CRC_INIT : crc_q;
	assign crc_d = sss_crc8_step(seed, i_byte);

	// The register only moves on a byte strobe.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			crc_q <= CRC_INIT;
		end else if (i_start || i_next) begin
			crc_q <= crc_d;
		end
	end

	assign o_crc = crc_q ^ CRC_FINAL_XOR;

endmodule
`default_nettype wire

// ==== tb/sss_cmd_core_sva.sv ====
// Port checks for the sensor command block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sss_cmd_core_chk (
	// Clock and reset.
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	// Bus pins.
	input  wire logic                 i_scl,
	input  wire logic                 i_sda,
	input  wire logic                 o_sda_o,
	input  wire logic                 o_sda_oe_n,
	// Event pulses.
	input  wire logic                 i_soft_rst_evt,
	input  wire logic                 i_supply_fail_evt,
	input  wire logic                 i_rh_alert_evt,
	input  wire logic                 i_t_alert_evt,
	// State outputs.
	input  wire logic                 o_heater_on,
	input  wire sss_pkg::sss_status_s o_status
);
	import sss_pkg::*;
	// Every check shares the core clock and is idle during reset.
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	property p_rst_val;
		$fell(i_rst) |-> o_status == 16'h8010 && !o_heater_on && o_sda_oe_n;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("Status after reset is wrong.");
	property p_heater_bit;
		o_status.heater == o_heater_on;
	endproperty
	a_heater_bit: assert property (p_heater_bit) else $error("Heater bit differs from heater.");
	// The heater only moves on a soft reset or on the clock fall that closes a command byte.
	// That fall reaches the sampled flag four clocks later: two synchroniser stages, the flag, then the checker's own sample.
	property p_heater_src;
		$changed(o_heater_on) |-> $past(i_soft_rst_evt) || ($past(i_scl, 4) && !$past(i_scl, 3));
	endproperty
	a_heater_src: assert property (p_heater_src) else $error("Heater moved without a command.");
	// The data pin may only ever be pulled low, never driven high.
	property p_rsv_zero;
		{o_status.rsv14, o_status.rsv12, o_status.rsv9_5, o_status.rsv3_2} == 9'h000 && !o_sda_o;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("Reserved bits not zero.");
	property p_alert_pend;
		o_status.rh_alert || o_status.t_alert |-> o_status.alert_pend;
	endproperty
	a_alert_pend: assert property (p_alert_pend) else $error("Alert without pending flag.");
	property p_rh_evt;
		i_rh_alert_evt |=> o_status.rh_alert && o_status.alert_pend;
	endproperty
	a_rh_evt: assert property (p_rh_evt) else $error("Humidity alert not flagged.");
	property p_t_evt;
		i_t_alert_evt |=> o_status.t_alert && o_status.alert_pend;
	endproperty
	a_t_evt: assert property (p_t_evt) else $error("Temperature alert not flagged.");
	property p_rst_evt;
		i_soft_rst_evt || i_supply_fail_evt |=> o_status.sys_reset;
	endproperty
	a_rst_evt: assert property (p_rst_evt) else $error("Reset event not flagged.");
	property p_soft_heater;
		i_soft_rst_evt |=> !o_heater_on ##1 !o_heater_on;
	endproperty
	a_soft_heater: assert property (p_soft_heater) else $error("Heater on after soft reset.");
	c_heater: cover property ($rose(o_heater_on));
	c_clear: cover property ($fell(o_status.sys_reset));
	c_wcrc: cover property ($rose(o_status.wcrc_err));
endmodule
bind sss_cmd_core sss_cmd_core_chk u_chk (
	.i_clk, .i_rst, .i_scl, .i_sda, .o_sda_o, .o_sda_oe_n, .i_soft_rst_evt,
	.i_supply_fail_evt, .i_rh_alert_evt, .i_t_alert_evt, .o_heater_on, .o_status
);
`default_nettype wire

// ==== tb/sss_i2c_host.sv ====
// Host controller model for the two-wire bus, open drain on the data line.
// Assumes the sensor samples the pins on the same 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sss_i2c_host (
	// Clock.
	input  wire logic i_clk,
	// Sensor data drive, pulled low while the enable is low.
	input  wire logic i_sda_o,
	input  wire logic i_sda_oe_n,
	// Bus lines as seen on the wire.
	output logic      o_scl,
	output logic      o_sda
);
	import sss_pkg::*;
	logic sda_q; // Host drive, 1 releases the line to the pull-up.
	initial begin
		sda_q = 1'b1;
		o_scl = 1'b1;
	end
	// Wired-AND: the pull-up wins unless a party pulls low.
	assign o_sda = sda_q & (i_sda_oe_n | i_sda_o);
	// Both lines change just after an edge, then hold for n clocks.
	task automatic step(input logic d, input logic c, input int n);
		sda_q <= d;
		o_scl <= c;
		repeat (n) @(posedge i_clk);
	endtask
	// Low phase of 8 clocks keeps well above the sensor's minimum.
	task automatic bit_io(input logic b, output logic r);
		step(b, 1'b0, 6);
		step(b, 1'b1, 8);
		r = o_sda;
		step(b, 1'b0, 2);
	endtask
	task automatic start();
		step(1'b1, o_scl, 6);
		step(1'b1, 1'b1, 8);
		step(1'b0, 1'b1, 8);
		step(1'b0, 1'b0, 2);
	endtask
	task automatic stop();
		step(1'b0, 1'b0, 6);
		step(1'b0, 1'b1, 8);
		step(1'b1, 1'b1, 8);
	endtask
	// Eight bits most significant first, then the acknowledge slot.
	task automatic xfer(input logic [7:0] b, input logic ak, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r[i]);
		end
		bit_io(ak, a);
	endtask
	task automatic wb(input logic [7:0] b, inout logic nak);
		logic [7:0] r;
		logic       a;
		xfer(b, 1'b1, r, a);
		nak = nak | a;
	endtask
	// Bitwise checksum, kept apart from the design's byte-wise one.
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	// Command word, then an optional data word with its checksum; flip corrupts it.
	task automatic wr(input logic [15:0] c, input logic dat, input logic [15:0] d, input logic [7:0] flip,
		output logic nak);
		nak = 1'b0;
		start();
		wb({BUS_ADDR, 1'b0}, nak);
		wb(c[15:8], nak);
		wb(c[7:0], nak);
		if (dat) begin
			wb(d[15:8], nak);
			wb(d[7:0], nak);
			wb(crc8(d) ^ flip, nak);
		end
		stop();
	endtask
	// Status read: command, read header, two bytes and checksum, NACK ends.
	task automatic rd(output logic [15:0] w, output logic [7:0] k, output logic nak);
		logic a;
		wr(CMD_READ_STAT, 1'b0, 16'h0000, 8'h00, nak);
		start();
		wb({BUS_ADDR, 1'b1}, nak);
		xfer(8'hFF, 1'b0, w[15:8], a);
		xfer(8'hFF, 1'b0, w[7:0], a);
		xfer(8'hFF, 1'b1, k, a);
		stop();
	endtask
endmodule
`default_nettype wire

// ==== tb/test_sensor_status_heater_crc.sv ====
// Self-checking bench for the sensor command block.
// Assumes the host model and the bound port checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module test_sensor_status_heater_crc;
	import sss_pkg::*;
	logic        clk = 1'b0;   // 100 MHz clock.
	logic        rst = 1'b1;   // Synchronous reset.
	logic [3:0]  evt = 4'h0;   // Soft reset, supply fail, humidity and temperature alert pulses.
	wire         scl;          // Bus clock wire.
	wire         sda;          // Bus data wire.
	logic        sda_o;        // Sensor data value.
	logic        sda_oe_n;     // Sensor pull-down enable.
	logic        heater;       // Heater state.
	sss_status_s st;           // Status word.
	int          n_fail = 0;
	int          num_checks = 0;
	logic [15:0] w;
	logic [7:0]  k;
	logic        nak;
	always #5 clk = ~clk;
	sss_cmd_core dut (.i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
		.i_soft_rst_evt(evt[3]), .i_supply_fail_evt(evt[2]), .i_rh_alert_evt(evt[1]), .i_t_alert_evt(evt[0]),
		.o_heater_on(heater), .o_status(st));
	sss_i2c_host host (.i_clk(clk), .i_sda_o(sda_o), .i_sda_oe_n(sda_oe_n), .o_scl(scl), .o_sda(sda));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Let pending updates land before looking at the port state.
	task automatic stat(input logic [15:0] exp);
		repeat (4) @(posedge clk);
		#1;
		chk(st, exp);
		chk({15'h0000, heater}, {15'h0000, exp[13]});
	endtask
	// The read command itself succeeds, so the word read never shows bit 1.
	task automatic busst(input logic [15:0] exp);
		host.rd(w, k, nak);
		chk({15'h0000, nak}, 16'h0000);
		chk(w, exp);
		chk({8'h00, k}, {8'h00, host.crc8(exp)});
	endtask
	task automatic cmd(input logic [15:0] c);
		host.wr(c, 1'b0, 16'h0000, 8'h00, nak);
		chk({15'h0000, nak}, 16'h0000);
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		evt[i] <= 1'b1;
		@(posedge clk);
		evt <= 4'h0;
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		// The bench's own checksum must agree with the known example word first.
		chk({8'h00, host.crc8(16'hBEEF)}, 16'h0092);
		stat(16'h8010);
		busst(16'h8010);
		cmd(CMD_HEATER_ON);
		stat(16'hA010);
		busst(16'hA010);
		cmd(CMD_CLEAR_STAT);
		stat(16'h2000);
		cmd(16'h3099);
		stat(16'h2002);
		cmd(CMD_HEATER_OFF);
		stat(16'h0000);
		pulse(1);
		stat(16'h8800);
		pulse(0);
		stat(16'h8C00);
		pulse(2);
		stat(16'h8C10);
		cmd(CMD_CLEAR_STAT);
		stat(16'h0000);
		host.wr(CMD_HEATER_ON, 1'b1, 16'hBEEF, 8'h01, nak);
		stat(16'h2003);
		host.wr(CMD_HEATER_ON, 1'b1, 16'hBEEF, 8'h00, nak);
		stat(16'h2000);
		pulse(3);
		stat(16'h0010);
		// A foreign address must be left unanswered.
		host.start();
		host.xfer(8'h24, 1'b1, k, nak);
		chk({15'h0000, nak}, 16'h0001);
		host.stop();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		stat(16'h8010);
		print_verdict();
	end
	// A hung bus cuts the run short here.
	initial begin
		repeat (100000) @(posedge clk);
		$display("Error at %0t: run did not finish", $time);
		n_fail++;
		print_verdict();
	end
endmodule
`default_nettype wire
